// ===== rtl/aldec_pkg.sv
/*
 * constants and carrier types for the dma enable control bank of the audio link controller.
 * assumes a 32-bit word-only avalon-mm slave, one clock, async active-low reset.
 */
// Operation
// [R1] modem rx overrun halts its dma when enabled
// [R2] modem tx underrun halts its dma when enabled
// [R3] audio rx overrun halts its dma when enabled
// [R4] lowfreq tx underrun halts its dma when enabled
// [R5] center tx underrun halts its dma when enabled
// [R6] surround tx underrun halts its dma when enabled
// [R7] pcm tx underrun halts its dma when enabled
// [R8] bits 15,14 enable modem rx/tx dma
// [R9] bit 12 enables audio rx dma, reads back
// [R10] bits 11,10 enable lowfreq/center dma, read back
// [R11] bits 9,8 enable surround/pcm dma, read back
// [R12] enables reset zero; write one sets, zero ignored
// [R13] halt enable bits read back their state
// [R14] bits 31:24, 21, 13 reserved, read zero
// [R15] software sizes tx dma at least fifo depth
// [R16] disable register write one clears matching bit
// [R17] software recovers stream by disable, enable, restart
// [R18] one write sets several bits at once
package aldec_pkg;
    localparam logic [15:0] ctl_enable_set_off = 16'hf700;
    localparam logic [15:0] ctl_disable_clear_off = 16'hf704;
    localparam logic [15:0] stream_status_off = 16'hf780;
    localparam logic [31:0] ctl_reset_val = 32'h0000_0000;
    // implemented bits: 23:22, 20:14, 12:8
    localparam logic [31:0] ctl_impl_mask = 32'h00df_df00;
    localparam int dma_en_lsb = 8;
    localparam int halt_en_lsb = 16;
    localparam int num_streams = 8;
    // stream index: 0 pcm,1 surround,2 center,3 lowfreq,4 audio rx,5 unused,6 modem tx,7 modem rx
    localparam logic [7:0] stream_impl = 8'hdf;
    localparam int unsigned clk_mhz = 200;

    typedef struct packed {
        logic [7:0] err; // overrun or underrun pulse per stream
        logic [7:0] req; // raw dma request from fifo logic per stream
    } aldec_stream_in_s;

    typedef struct packed {
        logic [7:0] halted;
        logic [7:0] req;
    } aldec_stream_out_s;
endpackage

// ===== rtl/aldec_stream_gate.sv
/*
 * per-stream dma request gate with error halt latch.
 * assumes err pulses are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module aldec_stream_gate (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic dma_en,
    input wire logic halt_en,
    input wire logic err,
    input wire logic req_in,
    output logic req_out,
    output logic halted
);
    logic halted_reg;
    logic halted_next;
    logic req_reg;

    // halt sticks until the stream is disabled; the set wins over the clear
    assign halted_next = (halt_en & err) | (halted_reg & dma_en);
    // registered so a request never glitches in the cycle the error arrives
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            halted_reg <= 1'b0;
            req_reg <= 1'b0;
        end else begin
            halted_reg <= halted_next; // [R1] [R2] [R3] [R4] [R5] [R6] [R7]
            req_reg <= req_in & dma_en & ~halted_next & ~(halt_en & err); // [R1] [R7]
        end
    end
    assign req_out = req_reg;
    assign halted = halted_reg;

    a_halt_blocks_req: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
        halted_reg |=> !req_reg)
        else $error("request issued while halted");
    a_err_latches_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
        (halt_en && err) |=> halted_reg)
        else $error("error with halt enabled did not halt");
    a_no_halt_no_stop: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R1] [R7]
        (!halt_en && !halted_reg && dma_en && req_in) |=> req_reg)
        else $error("request dropped with halt disabled");
endmodule // aldec_stream_gate

// ===== rtl/aldec_ctl.sv
/*
 * control enable/disable register bank with per-stream dma gating.
 * assumes a word-only avalon-mm master; byte enables other than all-ones are ignored writes.
 */
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module aldec_ctl #(
    parameter int addr_w = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [addr_w-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire aldec_pkg::aldec_stream_in_s stream_in,
    output aldec_pkg::aldec_stream_out_s stream_out
);
    logic [31:0] ctl_reg;
    logic [31:0] ctl_next;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic ack_reg;
    logic [7:0] halted_w;
    logic [7:0] req_w;

    // one comparator shape for every mapped register
    function automatic logic addr_hit(input logic [addr_w-1:0] a, input logic [15:0] off);
        return a == addr_w'(off);
    endfunction

    wire access = (avs_read | avs_write) & ~ack_reg;
    wire hit_set = addr_hit(avs_address, aldec_pkg::ctl_enable_set_off);
    wire hit_clr = addr_hit(avs_address, aldec_pkg::ctl_disable_clear_off);
    wire hit_sts = addr_hit(avs_address, aldec_pkg::stream_status_off);
    wire full_word = avs_byteenable == 4'hf;
    wire wr_set = access & avs_write & hit_set & full_word;
    wire wr_clr = access & avs_write & hit_clr & full_word;
    wire unmapped = ~(hit_set | hit_clr | hit_sts);
    wire [31:0] wmask = avs_writedata & aldec_pkg::ctl_impl_mask; // [R14]
    wire [31:0] rd_mux = hit_sts ? {16'h0000, halted_w, req_w} :
                         (hit_set | hit_clr) ? ctl_reg : 32'h0000_0000;

    // set on one, zero ignored; all ones of one word take effect together
    assign ctl_next = wr_set ? (ctl_reg | wmask) : // [R12] [R18] [R8] [R9] [R10] [R11] [R13]
                      wr_clr ? (ctl_reg & ~wmask) : ctl_reg; // [R16]

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_reg <= aldec_pkg::ctl_reset_val; // [R12]
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            ack_reg <= access;
            if (access) begin
                rdata_reg <= avs_read ? rd_mux : 32'h0000_0000;
                err_reg <= unmapped | ~full_word;
            end
        end
    end

    // one wait cycle: request sampled, answered at the next edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;
    assign avs_response_err = err_reg;

    genvar gi;
    generate
        for (gi = 0; gi < aldec_pkg::num_streams; gi++) begin : g_stream
            if (aldec_pkg::stream_impl[gi]) begin : g_on
                aldec_stream_gate u_gate (
                    .sys_clk(sys_clk),
                    .rst_b(rst_b),
                    .dma_en(ctl_reg[aldec_pkg::dma_en_lsb + gi]),
                    .halt_en(ctl_reg[aldec_pkg::halt_en_lsb + gi]),
                    .err(stream_in.err[gi]),
                    .req_in(stream_in.req[gi]),
                    .req_out(req_w[gi]),
                    .halted(halted_w[gi])
                );
            end else begin : g_off
                assign req_w[gi] = 1'b0;
                assign halted_w[gi] = 1'b0;
            end
        end
    endgenerate

    assign stream_out.req = req_w;
    assign stream_out.halted = halted_w;

    // halt armed and the stream reports its error in the same cycle
    sequence s_err_armed(halt_bit, err_bit);
        halt_bit && err_bit;
    endsequence

    // the gated request then stays low for the two cycles that follow
    sequence s_req_quiet(req_bit);
        !req_bit [*2];
    endsequence

    a_zero_no_effect: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
        wr_set |=> ((ctl_reg & $past(ctl_reg)) == $past(ctl_reg)))
        else $error("write-one-set cleared a bit");
    a_multi_set: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R18]
        wr_set |=> ((ctl_reg & $past(wmask)) == $past(wmask)))
        else $error("written ones not all set");
    a_clear_bits: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
        wr_clr |=> ((ctl_reg & $past(wmask)) == 32'h0000_0000))
        else $error("disable write left bit set");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
        (ctl_reg & ~aldec_pkg::ctl_impl_mask) == 32'h0000_0000)
        else $error("reserved bit set");
    a_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R9]
        (access && avs_read && hit_set) |=> (avs_readdata == $past(ctl_reg)))
        else $error("readback mismatch");
    a_halt_readback: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R13]
        (access && avs_read && hit_set) |=> (avs_readdata[23:16] == $past(ctl_reg[23:16])))
        else $error("halt enable readback mismatch");
    a_disabled_no_req: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
        !ctl_reg[aldec_pkg::dma_en_lsb] |=> !req_w[0])
        else $error("pcm request while disabled");
    a_modem_rx_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R1]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 7], stream_in.err[7])
        |=> s_req_quiet(req_w[7]))
        else $error("modem rx request after overrun");
    a_modem_tx_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R2]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 6], stream_in.err[6])
        |=> s_req_quiet(req_w[6]))
        else $error("modem tx request after underrun");
    a_audio_rx_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 4], stream_in.err[4])
        |=> s_req_quiet(req_w[4]))
        else $error("audio rx request after overrun");
    a_lowfreq_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 3], stream_in.err[3])
        |=> s_req_quiet(req_w[3]))
        else $error("lowfreq request after underrun");
    a_center_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 2], stream_in.err[2])
        |=> s_req_quiet(req_w[2]))
        else $error("center request after underrun");
    a_surround_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb + 1], stream_in.err[1])
        |=> s_req_quiet(req_w[1]))
        else $error("surround request after underrun");
    a_pcm_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
        s_err_armed(ctl_reg[aldec_pkg::halt_en_lsb], stream_in.err[0])
        |=> s_req_quiet(req_w[0]))
        else $error("pcm request after underrun");
    a_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_b)
        access |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");
endmodule // aldec_ctl

// ===== sim/aldec_dma_model.sv
/* far-side stream model: raw dma requests on every implemented stream, error pulses on command.
   assumes the bench holds err_cmd for one cycle per pulse. */
`timescale 1ns/1ps
module aldec_dma_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] err_cmd,
    output aldec_pkg::aldec_stream_in_s stream_in
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stream_in <= '0;
        end else begin
            // transfers never run short of the fifo, so requests stay up
            stream_in.req <= aldec_pkg::stream_impl;
            stream_in.err <= err_cmd & aldec_pkg::stream_impl;
        end
    end
endmodule // aldec_dma_model

// ===== sim/aldec_bench.sv
/* bench for aldec_ctl: table of w1s writes with readback, refusals, error halt and recovery.
   assumes aldec_dma_model on the stream side. */
`timescale 1ns/1ps
module aldec_bench;
    logic sys_clk = 0;
    logic rst_b = 0;
    logic [15:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic avs_response_err;
    logic [7:0] err_cmd = '0;
    logic [7:0] halted_mask = '0;
    logic [31:0] rd;
    logic rerr;
    int n_errors = 0;
    int comparisons = 0;
    aldec_pkg::aldec_stream_in_s stream_in;
    aldec_pkg::aldec_stream_out_s stream_out;
    // written value, then expected readback
    logic [63:0] rows [7] = '{64'h0000_0100_0000_0100, 64'h0000_0200_0000_0300,
        64'h0000_0c00_0000_0f00, 64'h0000_1000_0000_1f00, 64'h0000_e000_0000_df00,
        64'h0000_0000_0000_df00, 64'hffff_2000_00df_df00};
    aldec_ctl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
        .stream_in(stream_in), .stream_out(stream_out));
    aldec_dma_model model_u (.sys_clk(sys_clk), .rst_b(rst_b), .err_cmd(err_cmd),
        .stream_in(stream_in));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // iff sees pre-edge waitrequest, so the answer is taken at the completing edge
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge sys_clk iff (avs_waitrequest === 1'b0));
        rd = avs_readdata;
        rerr = avs_response_err;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic pulse(input logic [7:0] m);
        err_cmd <= m;
        @(posedge sys_clk);
        err_cmd <= '0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus(1'b0, 16'hf700, '0);
        check("reset value", 32'h0, rd);
        foreach (rows[i]) begin
            bus(1'b1, 16'hf700, rows[i][63:32]);
            bus(1'b0, 16'hf700, '0);
            check("readback", rows[i][31:0], rd);
        end
        // the disable register reads back the same enable word
        bus(1'b0, 16'hf704, '0);
        check("disable readback", 32'h00df_df00, rd);
        bus(1'b1, 16'hf704, 32'h00df_df00);
        bus(1'b0, 16'hf700, '0);
        check("cleared", 32'h0, rd);
        bus(1'b0, 16'hf7f0, '0);
        check("unmapped err", 32'h1, {31'h0, rerr});
        avs_byteenable <= 4'h3;
        bus(1'b1, 16'hf700, 32'h0000_ff00);
        check("partial err", 32'h1, {31'h0, rerr});
        avs_byteenable <= 4'hf;
        bus(1'b0, 16'hf700, '0);
        check("partial ignored", 32'h0, rd);
        bus(1'b1, 16'hf700, 32'h00df_df00);
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            if (aldec_pkg::stream_impl[i]) begin
                pulse(8'h01 << i);
                halted_mask[i] = 1'b1;
                check("halt", {16'h0, 8'hdf & ~halted_mask, halted_mask},
                    {16'h0, stream_out.req, stream_out.halted});
            end
        end
        // status word: halted streams in bits 15:8, gated requests in bits 7:0
        bus(1'b0, 16'hf780, '0);
        check("status", 32'h0000_df00, rd);
        bus(1'b1, 16'hf704, 32'h00df_df00);
        bus(1'b1, 16'hf700, 32'h0000_df00);
        pulse(8'hdf);
        check("no halt", 32'h0000_df00, {16'h0, stream_out.req, stream_out.halted});
        // reset in mid-run must drop every enable, halt and request
        rst_b <= 1'b0;
        @(posedge sys_clk);
        check("reset streams", 32'h0, {16'h0, stream_out.req, stream_out.halted});
        rst_b <= 1'b1;
        bus(1'b0, 16'hf700, '0);
        check("reset again", 32'h0, rd);
        close_out;
    end
endmodule // aldec_bench
